// ===== bench/serial_irq_controller_test.sv
// Purpose: self-checking bench of the serial interrupt controller
// Assumes: stimulus changes on the falling clock edge
// Notes: a frame takes about 65 clocks, so settings get 150 to show
`timescale 1ns/1ns
module serial_irq_controller_test
    import sirqc_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic pcie_fund_reset_n_i = 1'b1;
    logic global_reset_pin_n_i = 1'b1;
    logic cfg_req_i = 1'b0;
    logic cfg_wr_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00;
    logic [3:0] cfg_be_i = 4'h0;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic cfg_ack_o;
    logic [31:0] cfg_rdata_o;
    logic sirq_w;
    logic sirq_o;
    logic sirq_oe_o;
    logic [15:0] irq_o;
    logic drv_low;
    logic [15:0] vec = 16'h0;
    logic kick = 1'b0;
    logic [3:0] lo_run = 4'h0;
    logic [3:0] start_len = 4'h0;
    logic rec_oe = 1'b0;
    logic rec_o = 1'b0;
    logic [31:0] rdv;
    logic [3:0] wl [4] = '{SIRQC_START_4, SIRQC_START_6, SIRQC_START_8, SIRQC_START_4};
    int starts = 0;
    int n = 0;
    int errors = 0;
    int compares = 0;

    always #50 core_clk_i = ~core_clk_i;
    // pull-up holds the wire high whenever nobody drives it
    assign sirq_w = (sirq_oe_o ? sirq_o : 1'b1) & ~drv_low;

    sirqc_top dut_u (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .pcie_fund_reset_n_i(pcie_fund_reset_n_i),
        .global_reset_pin_n_i(global_reset_pin_n_i),
        .cfg_req_i(cfg_req_i),
        .cfg_wr_i(cfg_wr_i),
        .cfg_addr_i(cfg_addr_i),
        .cfg_be_i(cfg_be_i),
        .cfg_wdata_i(cfg_wdata_i),
        .cfg_ack_o(cfg_ack_o),
        .cfg_rdata_o(cfg_rdata_o),
        .sirq_i(sirq_w),
        .sirq_o(sirq_o),
        .sirq_oe_o(sirq_oe_o),
        .irq_o(irq_o)
    );

    sirqc_peer peer_u (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .wire_i(sirq_w),
        .assert_i(vec),
        .kick_i(kick),
        .drv_low_o(drv_low)
    );

    // low runs of 4 or more are start frames; stops are shorter
    always @(posedge core_clk_i) begin
        if (sirq_oe_o && !sirq_o) begin
            lo_run <= lo_run + 4'h1;
        end else begin
            if (lo_run >= 4'h4) begin
                start_len <= lo_run;
                rec_oe <= sirq_oe_o;
                rec_o <= sirq_o;
                starts <= starts + 1;
            end
            lo_run <= 4'h0;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t ns: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd);
        cfg_req_i = 1'b1;
        cfg_wr_i = w;
        cfg_addr_i = a;
        cfg_be_i = be;
        cfg_wdata_i = wd;
        cyc(1);
        cfg_req_i = 1'b0;
        rdv = cfg_rdata_o;
        chk({31'h0, cfg_ack_o}, 32'h1, "acknowledge");
        cyc(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
        acc(1'b1, a, be, wd);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 4'hF, 32'h0);
        chk(rdv, exp, "read data");
    endtask

    task automatic note(input string t);
        $display("test %s finished", t);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // about five and a half times the expected run
    initial begin
        #1000000;
        errors++;
        tally_and_finish;
    end

    initial begin
        cyc(4);
        arst_n_i = 1'b1;
        cyc(1);
        rd(SIRQC_OFS_MODE, 32'h0);
        rd(SIRQC_OFS_STAT, 32'h0);
        rd(8'hE8, 32'h0);
        wr(SIRQC_OFS_MODE, 4'h1, 32'h0000_00F4);
        rd(SIRQC_OFS_MODE, 32'h0000_0004);
        note("reset");
        for (int i = 0; i < 4; i++) begin
            wr(SIRQC_OFS_MODE, 4'h1, {28'h0, i[1:0], 2'h0});
            cyc(150);
            chk({28'h0, start_len}, {28'h0, wl[i]}, "start width");
            chk({30'h0, rec_oe, rec_o}, 32'h3, "driven recovery");
        end
        wr(SIRQC_OFS_MODE, 4'h1, 32'h0000_0001);
        cyc(150);
        chk({31'h0, rec_oe}, 32'h0, "released recovery");
        note("widths");
        wr(SIRQC_OFS_MODE, 4'hD, 32'hF0F0_0000);
        rd(SIRQC_OFS_MODE, 32'hF0F0_0000);
        vec = 16'h8421;
        cyc(150);
        rd(SIRQC_OFS_STAT, 32'h0000_8020);
        chk({16'h0, irq_o}, 32'h0000_8421, "line outputs");
        vec = 16'h0;
        cyc(150);
        rd(SIRQC_OFS_STAT, 32'h0000_8020);
        chk({16'h0, irq_o}, 32'h0000_8020, "held lines");
        wr(SIRQC_OFS_STAT, 4'h1, 32'h0000_FFFF);
        rd(SIRQC_OFS_STAT, 32'h0000_8000);
        wr(SIRQC_OFS_STAT, 4'h2, 32'h0000_8000);
        rd(SIRQC_OFS_STAT, 32'h0);
        vec = 16'h00A0;
        cyc(150);
        rd(SIRQC_OFS_STAT, 32'h0000_00A0);
        note("level status");
        vec = 16'h0;
        wr(SIRQC_OFS_MODE, 4'h1, 32'h0000_0002);
        cyc(150);
        wr(SIRQC_OFS_STAT, 4'h3, 32'h0000_FFFF);
        n = starts;
        cyc(200);
        chk(starts, n, "quiet frames");
        vec = 16'h0010;
        kick = 1'b1;
        cyc(1);
        kick = 1'b0;
        cyc(150);
        rd(SIRQC_OFS_STAT, 32'h0000_0010);
        note("quiet mode");
        vec = 16'h0;
        for (int p = 0; p < 2; p++) begin
            wr(SIRQC_OFS_MODE, 4'hD, 32'hFFFF_000F);
            pcie_fund_reset_n_i = (p != 0);
            global_reset_pin_n_i = (p != 1);
            cyc(4);
            pcie_fund_reset_n_i = 1'b1;
            global_reset_pin_n_i = 1'b1;
            cyc(4);
            rd(SIRQC_OFS_MODE, 32'h0);
            rd(SIRQC_OFS_STAT, 32'h0);
        end
        note("pin resets");
        tally_and_finish;
    end
endmodule

// ===== bench/sirqc_peer.sv
// Purpose: peripherals sharing the serial interrupt wire
// Assumes: the wire has a pull-up; slot k carries line k
// Notes: drives low only in sample cycles and for one wake-up clock
`timescale 1ns/1ns
module sirqc_peer (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic wire_i,
    input wire logic [15:0] assert_i,
    input wire logic kick_i,
    output logic drv_low_o
);
    logic [3:0] run;
    logic [5:0] cnt;
    logic act;
    logic skip;

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run <= 4'h0;
            cnt <= 6'h00;
            act <= 1'b0;
            skip <= 1'b0;
            drv_low_o <= 1'b0;
        end else begin
            run <= wire_i ? 4'h0 : run + 4'h1;
            cnt <= cnt + 6'h01;
            // slot k is driven in the cycle after count 3k
            drv_low_o <= (kick_i && !act) ||
                (act && cnt % 6'h03 == 6'h00 && assert_i[cnt / 6'h03]);
            if (act && cnt == 6'h2F) begin
                act <= 1'b0;
                skip <= 1'b1;
            end
            // low run after the last slot is the stop frame, not a start
            if (wire_i && run >= 4'h2 && !act) begin
                act <= !skip;
                skip <= 1'b0;
                cnt <= 6'h00;
            end
        end
    end
endmodule

// ===== src/sirqc_pkg.sv
// Purpose: shared constants and types of the serial interrupt controller
// Assumes: configuration dwords are addressed by byte offset, lanes by byte enables
// Notes: the mode and trigger registers share one dword, status sits in the next one
package sirqc_pkg;
    localparam logic [7:0] SIRQC_OFS_MODE = 8'hE0;
    localparam logic [7:0] SIRQC_OFS_TRIG = 8'hE2;
    localparam logic [7:0] SIRQC_OFS_STAT = 8'hE4;
    localparam int SIRQC_MODE_LANE = 0;
    localparam int SIRQC_TRIG_LANE = 2;
    localparam int SIRQC_STAT_LANE = 0;

    localparam int SIRQC_DRIVE_BIT = 0;
    localparam int SIRQC_POLL_BIT = 1;
    localparam int SIRQC_WIDTH_LSB = 2;
    localparam logic [3:0] SIRQC_MODE_RST = 4'h0;
    localparam logic [15:0] SIRQC_TRIG_RST = 16'h0000;
    localparam logic [15:0] SIRQC_STAT_RST = 16'h0000;
    localparam logic [3:0] SIRQC_MODE_PAD = 4'h0;

    localparam logic [1:0] SIRQC_WCODE_4 = 2'h0;
    localparam logic [1:0] SIRQC_WCODE_6 = 2'h1;
    localparam logic [1:0] SIRQC_WCODE_8 = 2'h2;
    localparam logic [3:0] SIRQC_START_4 = 4'h4;
    localparam logic [3:0] SIRQC_START_6 = 4'h6;
    localparam logic [3:0] SIRQC_START_8 = 4'h8;
    localparam logic [3:0] SIRQC_STOP_QUIET = 4'h2;
    localparam logic [3:0] SIRQC_STOP_CONT = 4'h3;
    localparam logic [3:0] SIRQC_CNT_FIRST = 4'h1;
    localparam logic [3:0] SIRQC_CNT_PEER = 4'h2;
    localparam logic [3:0] SIRQC_LAST_SLOT = 4'hF;
    localparam int SIRQC_LINES = 16;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_START_REC = 4'h2,
        ST_START_TA = 4'h3,
        ST_SLOT_SAMPLE = 4'h4,
        ST_SLOT_REC = 4'h5,
        ST_SLOT_TA = 4'h6,
        ST_STOP = 4'h7,
        ST_STOP_REC = 4'h8,
        ST_STOP_TA = 4'h9
    } sirqc_state_type;
endpackage

// ===== src/sirqc_sync.sv
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to core_clk_i
// Notes: only the second flop is visible outside
`timescale 1ns/1ns
module sirqc_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= RESET_VALUE;
            q_o <= RESET_VALUE;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// ===== src/sirqc_top.sv
// Purpose: serial interrupt frame master with mode, trigger and level status registers
// Assumes: PCI clock at 10 MHz; arst_n_i is the power-on reset
// Notes: configuration port answers every request one cycle later
//
// Summary of operation
// R1 - Start frame low for 4, 6 or 8 clocks by width code; code 00 default.
// R2 - Polling setting 0 runs continuous frames, 1 runs quiet mode.
// R3 - Recovery phase driven high when drive setting 0, released when 1.
// R4 - One trigger bit per line; 0 edge (default), 1 level.
// R5 - Level line signalled in its slot sets its status bit.
// R6 - Writing one to a status bit clears it and re-arms the line.
// R7 - Edge-configured lines never set a status bit.
// R8 - Upper four bits of the mode register read as zero.
// R9 - Fundamental reset, global reset pin or power-on reset restore settings.
// R10 - Sixteen data slots sampled in order 0 to 15; low means asserted.
// R11 - In quiet mode a peripheral starts a frame by one low clock.
`timescale 1ns/1ns
module sirqc_top
    import sirqc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic pcie_fund_reset_n_i,
    input wire logic global_reset_pin_n_i,
    input wire logic cfg_req_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    input wire logic sirq_i,
    output logic sirq_o,
    output logic sirq_oe_o,
    output logic [15:0] irq_o
);
    logic sirq_sync;
    logic fund_sync_n;
    logic global_reset_pin_sync_n;
    logic cfg_reset;

    sirqc_sync #(.RESET_VALUE(1'b1)) u_sync_sirq (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(sirq_i),
        .q_o(sirq_sync)
    );
    sirqc_sync #(.RESET_VALUE(1'b1)) u_sync_fund (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(pcie_fund_reset_n_i),
        .q_o(fund_sync_n)
    );
    sirqc_sync #(.RESET_VALUE(1'b1)) u_sync_global_reset_pin (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(global_reset_pin_n_i),
        .q_o(global_reset_pin_sync_n)
    );

    assign cfg_reset = !fund_sync_n || !global_reset_pin_sync_n;

    // configuration registers
    logic [3:0] mode_ctrl;
    logic [15:0] trigger_type;
    logic [15:0] level_status;
    logic [3:0] next_mode_ctrl;
    logic [15:0] next_trigger_type;
    logic [15:0] next_level_status;
    logic [31:0] next_cfg_rdata;
    logic next_cfg_ack;
    logic [15:0] status_set;
    logic [15:0] status_clr;
    logic hit_mode;
    logic hit_stat;
    logic quiet_polling_sel;
    logic recovery_drive_sel;
    logic [3:0] start_width;

    assign quiet_polling_sel = mode_ctrl[SIRQC_POLL_BIT];
    assign recovery_drive_sel = mode_ctrl[SIRQC_DRIVE_BIT];
    assign hit_mode = cfg_req_i && (cfg_addr_i[7:2] == SIRQC_OFS_MODE[7:2]);
    assign hit_stat = cfg_req_i && (cfg_addr_i[7:2] == SIRQC_OFS_STAT[7:2]);

    always_comb begin
        // reserved code 11 falls back to the shortest width
        case (mode_ctrl[SIRQC_WIDTH_LSB +: 2])
            SIRQC_WCODE_4: start_width = SIRQC_START_4; // R1
            SIRQC_WCODE_6: start_width = SIRQC_START_6; // R1
            SIRQC_WCODE_8: start_width = SIRQC_START_8; // R1
            default: start_width = SIRQC_START_4;
        endcase
    end

    always_comb begin
        next_mode_ctrl = mode_ctrl;
        next_trigger_type = trigger_type;
        status_clr = 16'h0000;
        next_cfg_ack = cfg_req_i;
        next_cfg_rdata = 32'h0000_0000;
        if (hit_mode && cfg_wr_i) begin
            if (cfg_be_i[SIRQC_MODE_LANE]) begin
                next_mode_ctrl = cfg_wdata_i[8 * SIRQC_MODE_LANE +: 4]; // R8
            end
            if (cfg_be_i[SIRQC_TRIG_LANE]) begin
                next_trigger_type[7:0] = cfg_wdata_i[8 * SIRQC_TRIG_LANE +: 8]; // R4
            end
            if (cfg_be_i[SIRQC_TRIG_LANE + 1]) begin
                next_trigger_type[15:8] = cfg_wdata_i[8 * (SIRQC_TRIG_LANE + 1) +: 8]; // R4
            end
        end
        if (hit_stat && cfg_wr_i) begin
            if (cfg_be_i[SIRQC_STAT_LANE]) begin
                status_clr[7:0] = cfg_wdata_i[8 * SIRQC_STAT_LANE +: 8]; // R6
            end
            if (cfg_be_i[SIRQC_STAT_LANE + 1]) begin
                status_clr[15:8] = cfg_wdata_i[8 * (SIRQC_STAT_LANE + 1) +: 8]; // R6
            end
        end
        if (hit_mode && !cfg_wr_i) begin
            next_cfg_rdata[8 * SIRQC_MODE_LANE +: 8] = {SIRQC_MODE_PAD, mode_ctrl}; // R8
            next_cfg_rdata[8 * SIRQC_TRIG_LANE +: 16] = trigger_type;
        end
        if (hit_stat && !cfg_wr_i) begin
            next_cfg_rdata[8 * SIRQC_STAT_LANE +: 16] = level_status;
        end
        // a new assertion in the clearing cycle is kept
        next_level_status = (level_status & ~status_clr) | status_set; // R6
        if (cfg_reset) begin
            next_mode_ctrl = SIRQC_MODE_RST; // R9
            next_trigger_type = SIRQC_TRIG_RST; // R9
            next_level_status = SIRQC_STAT_RST;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_ctrl <= SIRQC_MODE_RST; // R9
            trigger_type <= SIRQC_TRIG_RST; // R9
            level_status <= SIRQC_STAT_RST;
            cfg_ack_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            mode_ctrl <= next_mode_ctrl;
            trigger_type <= next_trigger_type;
            level_status <= next_level_status;
            cfg_ack_o <= next_cfg_ack;
            cfg_rdata_o <= next_cfg_rdata;
        end
    end

    // serial frame engine
    sirqc_state_type state;
    sirqc_state_type next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [3:0] slot_idx;
    logic [3:0] next_slot_idx;
    logic [15:0] edge_level;
    logic [15:0] next_edge_level;
    logic [3:0] stop_len;
    logic next_drive_low;
    logic next_drive_high;
    logic slot_asserted;

    assign stop_len = quiet_polling_sel ? SIRQC_STOP_QUIET : SIRQC_STOP_CONT; // R2
    // synced level in the turnaround cycle is the pin two clocks back: the sample phase
    assign slot_asserted = (state == ST_SLOT_TA) && !sirq_sync; // R10

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_slot_idx = slot_idx;
        next_edge_level = edge_level;
        status_set = 16'h0000;
        case (state)
            ST_IDLE: begin
                if (!quiet_polling_sel) begin
                    next_state = ST_START; // R2
                    next_cnt = SIRQC_CNT_FIRST;
                end else if (!sirq_sync) begin
                    // peripheral already spent one low clock of the start frame
                    next_state = ST_START; // R11
                    next_cnt = SIRQC_CNT_PEER;
                end
            end
            ST_START: begin
                if (cnt >= start_width) begin
                    next_state = ST_START_REC; // R1
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            ST_START_REC: next_state = ST_START_TA;
            ST_START_TA: begin
                next_state = ST_SLOT_SAMPLE;
                next_slot_idx = 4'h0;
            end
            ST_SLOT_SAMPLE: next_state = ST_SLOT_REC;
            ST_SLOT_REC: next_state = ST_SLOT_TA;
            ST_SLOT_TA: begin
                for (int i = 0; i < SIRQC_LINES; i++) begin
                    if (slot_idx == i[3:0]) begin
                        next_edge_level[i] = slot_asserted; // R4
                        status_set[i] = slot_asserted && trigger_type[i]; // R5 R7
                    end
                end
                if (slot_idx == SIRQC_LAST_SLOT) begin
                    next_state = ST_STOP; // R10
                    next_cnt = SIRQC_CNT_FIRST;
                end else begin
                    next_state = ST_SLOT_SAMPLE; // R10
                    next_slot_idx = slot_idx + 4'h1;
                end
            end
            ST_STOP: begin
                if (cnt >= stop_len) begin
                    next_state = ST_STOP_REC;
                end else begin
                    next_cnt = cnt + 4'h1;
                end
            end
            ST_STOP_REC: next_state = ST_STOP_TA;
            ST_STOP_TA: begin
                next_state = quiet_polling_sel ? ST_IDLE : ST_START; // R2
                next_cnt = SIRQC_CNT_FIRST;
            end
            default: next_state = ST_IDLE;
        endcase
        next_drive_low = (next_state == ST_START) || (next_state == ST_STOP);
        next_drive_high = ((next_state == ST_START_REC) || (next_state == ST_STOP_REC))
            && !recovery_drive_sel; // R3
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            slot_idx <= 4'h0;
            edge_level <= 16'h0000;
            sirq_o <= 1'b1;
            sirq_oe_o <= 1'b0;
            irq_o <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            slot_idx <= next_slot_idx;
            edge_level <= next_edge_level;
            sirq_o <= !next_drive_low;
            sirq_oe_o <= next_drive_low || next_drive_high; // R3
            // level lines stay up until software re-arms them
            irq_o <= (next_edge_level & ~next_trigger_type)
                | (next_level_status & next_trigger_type); // R4 R6
        end
    end

    // checking
    logic [3:0] h_low_len;
    logic h_quiet_entry;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            h_low_len <= 4'h0;
            h_quiet_entry <= 1'b0;
        end else begin
            h_low_len <= (state == ST_START && sirq_oe_o && !sirq_o) ? h_low_len + 4'h1 : 4'h0;
            h_quiet_entry <= (state == ST_IDLE) ? quiet_polling_sel : h_quiet_entry;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_start_end;
        state == ST_START_REC && $past(state) == ST_START;
    endsequence
    property p_start_width;
        s_start_end |-> (h_low_len + {3'h0, h_quiet_entry}) == $past(start_width);
    endproperty
    a_start_width: assert property (p_start_width) else $error("start frame width wrong"); // R1

    property p_poll_mode;
        state == ST_STOP_TA && !quiet_polling_sel |=> state == ST_START ##1 !sirq_o;
    endproperty
    a_poll_mode: assert property (p_poll_mode) else $error("continuous restart missing"); // R2

    property p_recovery_drive;
        (state == ST_START_REC || state == ST_STOP_REC)
            |-> sirq_oe_o == !$past(recovery_drive_sel) && sirq_o;
    endproperty
    a_recovery_drive: assert property (p_recovery_drive) else $error("recovery drive wrong"); // R3

    property p_edge_follow;
        state == ST_SLOT_TA && !cfg_reset && !trigger_type[slot_idx] && !(hit_mode && cfg_wr_i)
            |=> irq_o[$past(slot_idx)] == !$past(sirq_sync);
    endproperty
    a_edge_follow: assert property (p_edge_follow) else $error("edge line output wrong"); // R4

    property p_level_set;
        slot_asserted && trigger_type[slot_idx] && !cfg_reset
            |=> level_status[$past(slot_idx)] ##1 1'b1;
    endproperty
    a_level_set: assert property (p_level_set) else $error("level status not set"); // R5

    property p_clear;
        !cfg_reset && (status_clr & ~status_set) != 16'h0000
            |=> (level_status & $past(status_clr & ~status_set)) == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("status write-one did not clear"); // R6

    property p_edge_no_status;
        (level_status & ~$past(level_status) & ~$past(trigger_type)) == 16'h0000;
    endproperty
    a_edge_no_status: assert property (p_edge_no_status) else $error("edge line set status"); // R7

    property p_mode_pad;
        cfg_req_i && !cfg_wr_i && hit_mode |=> cfg_ack_o && cfg_rdata_o[7:4] == 4'h0;
    endproperty
    a_mode_pad: assert property (p_mode_pad) else $error("mode upper bits not zero"); // R8

    property p_settings_reset;
        cfg_reset |=> mode_ctrl == SIRQC_MODE_RST && trigger_type == SIRQC_TRIG_RST;
    endproperty
    a_settings_reset: assert property (p_settings_reset) else $error("settings not reset"); // R9

    sequence s_slot_walk;
        state == ST_SLOT_SAMPLE ##1 state == ST_SLOT_REC ##1 state == ST_SLOT_TA;
    endsequence
    property p_slot_order;
        state == ST_START_TA |=> s_slot_walk ##1 state == ST_SLOT_SAMPLE && slot_idx == 4'h1;
    endproperty
    a_slot_order: assert property (p_slot_order) else $error("slot order broken"); // R10
endmodule
